// ---- verilog/led_display_config_regs.v ----
// configuration register bank and strip timing for the video-to-led-strip controller
// Operation
// - vertical crop origin, 11 bits, resets zero
// - horizontal crop origin, 11 bits, resets zero
// - window width is field plus one, reset 255
// - window height is field plus one, reset 31
// - leds per output, 10 bits, reset 256
// - 3-wire slot lasts strip period times divider+1
// - divider 0 gives 25.6 MHz slots, 1 gives 12.8
// - 4-wire divider 0..4 gives 8..0.5 MHz
// - strip clock fixed at 25.6 MHz
// - 3-wire pixel is exactly 24 bit slots
// - write-only 5-bit encoding select, reset zero
// - encoding select ignored in 4-wire mode
// - write-only bit 9 switches pre-emphasis
// - segment count field, 10 bits, reset zero
`timescale 1ns/1ns
`include "led_cfg_map.vh"
module led_display_config_regs #(
  parameter DATA_W = `PIXEL_W
) (
  // clock and reset
  input  wire                     CLK_I,
  input  wire                     RESET_N_I,
  // register access port from the configuration controller
  input  wire [3:0]               REG_ADDR_I,
  input  wire [15:0]              REG_WDATA_I,
  input  wire                     REG_WE_I,
  output reg  [15:0]              REG_RDATA_O,
  // strip mode and run control
  input  wire                     FOUR_WIRE_I,
  input  wire                     STRIP_RUN_I,
  // incoming video
  input  wire                     VID_VALID_I,
  input  wire [`COORD_W-1:0]      VID_X_I,
  input  wire [`COORD_W-1:0]      VID_Y_I,
  input  wire [DATA_W-1:0]        VID_DATA_I,
  // cropped video
  output wire                     CROP_VALID_O,
  output wire [`COORD_W-1:0]      CROP_X_O,
  output wire [`COORD_W-1:0]      CROP_Y_O,
  output wire [DATA_W-1:0]        CROP_DATA_O,
  // settings to the strip serialisers
  output wire [`FIELD10_W-1:0]    LEDS_PER_OUTPUT_O,
  output wire [`FIELD10_W-1:0]    SEGMENT_COUNT_O,
  output wire [`ENC_W-1:0]        BIT_ENCODING_SELECT_O,
  output wire                     PREEMPHASIS_ON_O,
  // strip timing
  output reg                      SLOT_TICK_O,
  output reg  [`SLOT_IDX_W-1:0]   SLOT_INDEX_O,
  output reg                      PIXEL_TICK_O,
  output reg  [`FIELD10_W-1:0]    LED_INDEX_O,
  output reg                      LINE_DONE_O,
  output reg                      SERIAL_CLK_O
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  reg [`COORD_W-1:0]   crop_left_q;
  reg [`COORD_W-1:0]   crop_top_q;
  reg [`FIELD10_W-1:0] window_width_minus_one_q;
  reg [`FIELD10_W-1:0] window_height_minus_one_q;
  reg [`FIELD10_W-1:0] leds_per_output_q;
  reg [`FIELD10_W-1:0] slot_divider_value_q;
  reg [`ENC_W-1:0]     bit_encoding_select_q;
  reg                  preemphasis_on_q;
  reg [`FIELD10_W-1:0] segment_count_q;

  // values above the field width are dropped: reserved bits are not stored
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      crop_left_q               <= `RST_COORD;
      crop_top_q                <= `RST_COORD;
      window_width_minus_one_q  <= `RST_WIN_WIDTH;
      window_height_minus_one_q <= `RST_WIN_HEIGHT;
      leds_per_output_q         <= `RST_STRIP_LENGTH;
      slot_divider_value_q      <= `RST_FIELD10;
      bit_encoding_select_q     <= `RST_ENC;
      preemphasis_on_q          <= 1'b0;
      segment_count_q           <= `RST_FIELD10;
    end else if (REG_WE_I) begin
      if (REG_ADDR_I == `OFS_CROP_LEFT) begin
        crop_left_q <= REG_WDATA_I[`COORD_W-1:0];
      end else if (REG_ADDR_I == `OFS_CROP_TOP) begin
        crop_top_q <= REG_WDATA_I[`COORD_W-1:0];
      end else if (REG_ADDR_I == `OFS_WIN_WIDTH) begin
        window_width_minus_one_q <= REG_WDATA_I[`FIELD10_W-1:0];
      end else if (REG_ADDR_I == `OFS_WIN_HEIGHT) begin
        window_height_minus_one_q <= REG_WDATA_I[`FIELD10_W-1:0];
      end else if (REG_ADDR_I == `OFS_STRIP_LENGTH) begin
        leds_per_output_q <= REG_WDATA_I[`FIELD10_W-1:0];
      end else if (REG_ADDR_I == `OFS_SLOT_DIVIDER) begin
        slot_divider_value_q <= REG_WDATA_I[`FIELD10_W-1:0];
      end else if (REG_ADDR_I == `OFS_ENC_PREEMPH) begin
        bit_encoding_select_q <= REG_WDATA_I[`ENC_MSB:`ENC_LSB];
        preemphasis_on_q      <= REG_WDATA_I[`PREEMPH_BIT];
      end else if (REG_ADDR_I == `OFS_SEGMENT_COUNT) begin
        segment_count_q <= REG_WDATA_I[`FIELD10_W-1:0];
      end
    end
  end

  // ****************************************************************
  // read-back, one cycle after the address
  // ****************************************************************
  reg [15:0] rdata_d;

  // the encoding register is write-only and reads zero, like unmapped offsets
  always @* begin
    rdata_d = 16'h0000;
    if (REG_ADDR_I == `OFS_CROP_LEFT) begin
      rdata_d = {5'h00, crop_left_q};
    end else if (REG_ADDR_I == `OFS_CROP_TOP) begin
      rdata_d = {5'h00, crop_top_q};
    end else if (REG_ADDR_I == `OFS_WIN_WIDTH) begin
      rdata_d = {6'h00, window_width_minus_one_q};
    end else if (REG_ADDR_I == `OFS_WIN_HEIGHT) begin
      rdata_d = {6'h00, window_height_minus_one_q};
    end else if (REG_ADDR_I == `OFS_STRIP_LENGTH) begin
      rdata_d = {6'h00, leds_per_output_q};
    end else if (REG_ADDR_I == `OFS_SLOT_DIVIDER) begin
      rdata_d = {6'h00, slot_divider_value_q};
    end else if (REG_ADDR_I == `OFS_SEGMENT_COUNT) begin
      rdata_d = {6'h00, segment_count_q};
    end else if (REG_ADDR_I == `OFS_STATUS) begin
      rdata_d = {6'h00, LED_INDEX_O};
    end
  end

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 16'h0000;
    end else begin
      REG_RDATA_O <= rdata_d;
    end
  end

  // ****************************************************************
  // settings out
  // ****************************************************************
  assign LEDS_PER_OUTPUT_O     = leds_per_output_q;
  assign SEGMENT_COUNT_O       = segment_count_q;
  assign BIT_ENCODING_SELECT_O = FOUR_WIRE_I ? `RST_ENC : bit_encoding_select_q;
  assign PREEMPHASIS_ON_O      = preemphasis_on_q;

  // ****************************************************************
  // crop window
  // ****************************************************************
  crop_window_filter #(
    .COORD_W (`COORD_W),
    .SIZE_W  (`FIELD10_W),
    .DATA_W  (DATA_W)
  ) u_crop (
    .clk_i       (CLK_I),
    .reset_n_i   (RESET_N_I),
    .left_i      (crop_left_q),
    .top_i       (crop_top_q),
    .width_m1_i  (window_width_minus_one_q),
    .height_m1_i (window_height_minus_one_q),
    .vid_valid_i (VID_VALID_I),
    .vid_x_i     (VID_X_I),
    .vid_y_i     (VID_Y_I),
    .vid_data_i  (VID_DATA_I),
    .out_valid_o (CROP_VALID_O),
    .out_x_o     (CROP_X_O),
    .out_y_o     (CROP_Y_O),
    .out_data_o  (CROP_DATA_O)
  );

  // ****************************************************************
  // strip clock, 3-wire slots
  // ****************************************************************
  wire run3 = STRIP_RUN_I && !FOUR_WIRE_I;
  wire strip_tick;

  // 25.6 MHz is no integer fraction of the core clock; ticks jitter by one core cycle
  frac_tick_gen #(
    .ACC_W   (`STRIP_ACC_W),
    .MODULUS (`STRIP_MOD)
  ) u_strip_tick (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .run_i     (run3),
    .inc_i     (`STRIP_INC),
    .tick_o    (strip_tick)
  );

  reg [`FIELD10_W-1:0] div_cnt_q;
  wire slot_end  = strip_tick && (div_cnt_q == slot_divider_value_q);
  wire pixel_end = slot_end && (SLOT_INDEX_O == `SLOTS_PER_PIXEL_M1);
  wire line_end  = pixel_end && (LED_INDEX_O == leds_per_output_q - 10'h001);

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_cnt_q    <= `RST_FIELD10;
      SLOT_TICK_O  <= 1'b0;
      SLOT_INDEX_O <= 5'h00;
      PIXEL_TICK_O <= 1'b0;
      LED_INDEX_O  <= `RST_FIELD10;
      LINE_DONE_O  <= 1'b0;
    end else if (!run3) begin
      div_cnt_q    <= `RST_FIELD10;
      SLOT_TICK_O  <= 1'b0;
      SLOT_INDEX_O <= 5'h00;
      PIXEL_TICK_O <= 1'b0;
      LED_INDEX_O  <= `RST_FIELD10;
      LINE_DONE_O  <= 1'b0;
    end else begin
      SLOT_TICK_O  <= slot_end;
      PIXEL_TICK_O <= pixel_end;
      LINE_DONE_O  <= line_end;
      if (strip_tick) begin
        // slot spans divider+1 strip periods: 0 gives 25.6 MHz, 1 gives 12.8 MHz
        div_cnt_q <= slot_end ? `RST_FIELD10 : div_cnt_q + 10'h001;
      end
      if (slot_end) begin
        SLOT_INDEX_O <= pixel_end ? 5'h00 : SLOT_INDEX_O + 5'h01;
      end
      if (pixel_end) begin
        LED_INDEX_O <= line_end ? `RST_FIELD10 : LED_INDEX_O + 10'h001;
      end
    end
  end

  // ****************************************************************
  // 4-wire serial clock
  // ****************************************************************
  wire run4 = STRIP_RUN_I && FOUR_WIRE_I;
  wire four_tick;
  wire [2:0] four_shift = (slot_divider_value_q > `FOUR_MAX_DIV) ?
                          3'h4 : slot_divider_value_q[2:0];
  wire [`FOUR_ACC_W-1:0] four_inc = `FOUR_INC_BASE >> four_shift;

  // divider values above 4 hold the slowest rate rather than stopping the line
  frac_tick_gen #(
    .ACC_W   (`FOUR_ACC_W),
    .MODULUS (`FOUR_MOD)
  ) u_four_tick (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .run_i     (run4),
    .inc_i     (four_inc),
    .tick_o    (four_tick)
  );

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SERIAL_CLK_O <= 1'b0;
    end else if (!run4) begin
      SERIAL_CLK_O <= 1'b0;
    end else if (four_tick) begin
      SERIAL_CLK_O <= ~SERIAL_CLK_O;
    end
  end

endmodule // led_display_config_regs

// ---- verilog/led_cfg_map.vh ----
// register offsets, field layouts, reset values and timing constants of the config bank
`ifndef LED_CFG_MAP_VH
`define LED_CFG_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CROP_LEFT        4'h0
`define OFS_CROP_TOP         4'h1
`define OFS_WIN_WIDTH        4'h2
`define OFS_WIN_HEIGHT       4'h3
`define OFS_STRIP_LENGTH     4'h4
`define OFS_SLOT_DIVIDER     4'h5
`define OFS_ENC_PREEMPH      4'h6
`define OFS_SEGMENT_COUNT    4'h7
`define OFS_STATUS           4'h8

// ****************************************************************
// field widths and positions
// ****************************************************************
`define COORD_W              11
`define FIELD10_W            10
`define ENC_W                5
`define ENC_LSB              0
`define ENC_MSB              4
`define PREEMPH_BIT          9
`define PIXEL_W              24
`define SLOT_IDX_W           5

// ****************************************************************
// reset values
// ****************************************************************
`define RST_COORD            11'h000
`define RST_WIN_WIDTH        10'h0ff
`define RST_WIN_HEIGHT       10'h01f
`define RST_STRIP_LENGTH     10'h100
`define RST_FIELD10          10'h000
`define RST_ENC              5'h00

// ****************************************************************
// timing: strip clock from a 125 MHz core clock
// ****************************************************************
`define CORE_CLK_KHZ         125000
`define STRIP_CLK_KHZ        25600
// strip tick: 125000 * 256 / 1250 = 25600 kHz
`define STRIP_ACC_W          11
`define STRIP_INC            11'h100
`define STRIP_MOD            11'h4e2
// 4-wire tick at twice the line rate: 125000 * 128 / 1000 = 16 MHz, toggles to 8 MHz
`define FOUR_ACC_W           10
`define FOUR_INC_BASE        10'h080
`define FOUR_MOD             10'h3e8
`define FOUR_MAX_DIV         10'h004
`define SLOTS_PER_PIXEL_M1   5'h17

`endif

// ---- verilog/frac_tick_gen.v ----
// fractional-rate tick generator: one pulse per modulus overflow of an accumulator
`timescale 1ns/1ns
module frac_tick_gen #(
  parameter ACC_W   = 11,
  parameter [ACC_W-1:0] MODULUS = 11'h4e2
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             reset_n_i,
  // control
  input  wire             run_i,
  input  wire [ACC_W-1:0] inc_i,
  // tick
  output reg              tick_o
);

  reg  [ACC_W-1:0] acc_q;
  wire [ACC_W:0]   sum = {1'b0, acc_q} + {1'b0, inc_i};

  // an accumulator instead of an integer divider keeps the long-term rate exact
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q  <= {ACC_W{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      acc_q  <= {ACC_W{1'b0}};
      tick_o <= 1'b0;
    end else if (sum >= {1'b0, MODULUS}) begin
      acc_q  <= sum[ACC_W-1:0] - MODULUS;
      tick_o <= 1'b1;
    end else begin
      acc_q  <= sum[ACC_W-1:0];
      tick_o <= 1'b0;
    end
  end

endmodule // frac_tick_gen

// ---- verilog/crop_window_filter.v ----
// passes only video pixels that fall inside the programmed crop window
`timescale 1ns/1ns
`include "led_cfg_map.vh"
module crop_window_filter #(
  parameter COORD_W = 11,
  parameter SIZE_W  = 10,
  parameter DATA_W  = 24
) (
  // clock and reset
  input  wire               clk_i,
  input  wire               reset_n_i,
  // window settings
  input  wire [COORD_W-1:0] left_i,
  input  wire [COORD_W-1:0] top_i,
  input  wire [SIZE_W-1:0]  width_m1_i,
  input  wire [SIZE_W-1:0]  height_m1_i,
  // incoming video
  input  wire               vid_valid_i,
  input  wire [COORD_W-1:0] vid_x_i,
  input  wire [COORD_W-1:0] vid_y_i,
  input  wire [DATA_W-1:0]  vid_data_i,
  // cropped video
  output reg                out_valid_o,
  output reg  [COORD_W-1:0] out_x_o,
  output reg  [COORD_W-1:0] out_y_o,
  output reg  [DATA_W-1:0]  out_data_o
);

  // one extra bit so origin + size never wraps back into the frame
  function in_span;
    input [COORD_W-1:0] pos;
    input [COORD_W-1:0] org;
    input [SIZE_W-1:0]  len_m1;
    reg   [COORD_W:0]   diff;
    begin
      diff    = {1'b0, pos} - {1'b0, org};
      in_span = (pos >= org) && (diff <= {{(COORD_W+1-SIZE_W){1'b0}}, len_m1});
    end
  endfunction

  wire hit_x = in_span(vid_x_i, left_i, width_m1_i);
  wire hit_y = in_span(vid_y_i, top_i, height_m1_i);
  wire keep  = vid_valid_i && hit_x && hit_y;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      out_x_o     <= {COORD_W{1'b0}};
      out_y_o     <= {COORD_W{1'b0}};
      out_data_o  <= {DATA_W{1'b0}};
    end else begin
      out_valid_o <= keep;
      if (keep) begin
        out_x_o    <= vid_x_i - left_i;
        out_y_o    <= vid_y_i - top_i;
        out_data_o <= vid_data_i;
      end
    end
  end

endmodule // crop_window_filter

// ---- test/led_display_config_regs_props.sv ----
// assertions on the ports of the configuration register bank
`timescale 1ns/1ns
`include "led_cfg_map.vh"
module led_display_config_regs_props (
  // clock and reset
  input logic        CLK_I,
  input logic        RESET_N_I,
  // register port
  input logic [3:0]  REG_ADDR_I,
  input logic [15:0] REG_WDATA_I,
  input logic        REG_WE_I,
  input logic [15:0] REG_RDATA_O,
  // mode and video
  input logic        FOUR_WIRE_I,
  input logic        STRIP_RUN_I,
  input logic        VID_VALID_I,
  input logic [10:0] VID_X_I,
  input logic [10:0] VID_Y_I,
  input logic        CROP_VALID_O,
  input logic [10:0] CROP_X_O,
  input logic [10:0] CROP_Y_O,
  // settings and timing
  input logic [9:0]  LEDS_PER_OUTPUT_O,
  input logic [4:0]  BIT_ENCODING_SELECT_O,
  input logic        PREEMPHASIS_ON_O,
  input logic        SLOT_TICK_O,
  input logic [4:0]  SLOT_INDEX_O,
  input logic        PIXEL_TICK_O,
  input logic        LINE_DONE_O,
  input logic        SERIAL_CLK_O
);
  // ****************************************************************
  // shadow of the window, kept 12 bits wide so the edge sum cannot wrap
  // ****************************************************************
  logic [10:0] left_q, top_q;
  logic [9:0]  wm1_q, hm1_q;
  wire  [11:0] right_w  = left_q + wm1_q;
  wire  [11:0] bottom_w = top_q + hm1_q;
  wire  [10:0] rel_x_w  = VID_X_I - left_q;
  wire  [10:0] rel_y_w  = VID_Y_I - top_q;
  wire         keep_w   = VID_VALID_I && VID_X_I >= left_q && VID_Y_I >= top_q &&
                          {1'b0, VID_X_I} <= right_w && {1'b0, VID_Y_I} <= bottom_w;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      left_q <= 11'h000;
      top_q  <= 11'h000;
      wm1_q  <= 10'h0ff;
      hm1_q  <= 10'h01f;
    end else if (REG_WE_I) begin
      case (REG_ADDR_I)
        `OFS_CROP_LEFT:  left_q <= REG_WDATA_I[10:0];
        `OFS_CROP_TOP:   top_q <= REG_WDATA_I[10:0];
        `OFS_WIN_WIDTH:  wm1_q <= REG_WDATA_I[9:0];
        `OFS_WIN_HEIGHT: hm1_q <= REG_WDATA_I[9:0];
        default: ;
      endcase
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_wo_reads_zero: assert property (REG_ADDR_I == `OFS_ENC_PREEMPH |=> REG_RDATA_O == 16'h0000)
    else $error("write-only register read back nonzero");
  a_len_readback: assert property ((REG_WE_I && REG_ADDR_I == `OFS_STRIP_LENGTH) ##1 (!REG_WE_I && REG_ADDR_I == `OFS_STRIP_LENGTH) |=> REG_RDATA_O == {6'h00, $past(REG_WDATA_I[9:0], 2)})
    else $error("strip length read-back wrong");
  a_len_output: assert property (REG_WE_I && REG_ADDR_I == `OFS_STRIP_LENGTH |=> LEDS_PER_OUTPUT_O == $past(REG_WDATA_I[9:0]))
    else $error("strip length output not updated");
  a_preemph_write: assert property (REG_WE_I && REG_ADDR_I == `OFS_ENC_PREEMPH |=> PREEMPHASIS_ON_O == $past(REG_WDATA_I[9]))
    else $error("pre-emphasis bit not taken");
  a_enc_write: assert property ((REG_WE_I && REG_ADDR_I == `OFS_ENC_PREEMPH) ##1 !FOUR_WIRE_I |-> BIT_ENCODING_SELECT_O == $past(REG_WDATA_I[4:0]))
    else $error("encoding select not taken");
  a_enc_four_wire: assert property (FOUR_WIRE_I |-> BIT_ENCODING_SELECT_O == 5'h00)
    else $error("encoding select active in four-wire mode");
  a_crop_keep: assert property (1'b1 |=> CROP_VALID_O == $past(keep_w))
    else $error("crop valid disagrees with window");
  a_crop_coords: assert property (CROP_VALID_O |-> CROP_X_O == $past(rel_x_w) && CROP_Y_O == $past(rel_y_w))
    else $error("crop coordinates wrong");
  a_slot_index_max: assert property (SLOT_INDEX_O <= 5'h17)
    else $error("slot index beyond 23");
  a_pixel_after_slots: assert property (PIXEL_TICK_O |-> SLOT_INDEX_O == 5'h00 && $past(SLOT_INDEX_O) == 5'h17)
    else $error("pixel tick not after slot 23");
  a_slot_spacing: assert property (SLOT_TICK_O |=> !SLOT_TICK_O [*3])
    else $error("slot ticks closer than strip clock");
  a_four_wire_quiet: assert property (FOUR_WIRE_I |=> !SLOT_TICK_O && !PIXEL_TICK_O)
    else $error("slot ticks in four-wire mode");
  a_stop_clears: assert property (!STRIP_RUN_I |=> !SLOT_TICK_O && !SERIAL_CLK_O && SLOT_INDEX_O == 5'h00)
    else $error("timing not cleared when stopped");
  c_crop_kept: cover property (CROP_VALID_O);
  c_pixel: cover property (PIXEL_TICK_O);
  c_line: cover property (LINE_DONE_O);
  c_wo_write: cover property (REG_WE_I && REG_ADDR_I == `OFS_ENC_PREEMPH);
endmodule // led_display_config_regs_props
bind led_display_config_regs led_display_config_regs_props led_display_config_regs_props_i (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WE_I(REG_WE_I), .REG_RDATA_O(REG_RDATA_O), .FOUR_WIRE_I(FOUR_WIRE_I),
  .STRIP_RUN_I(STRIP_RUN_I), .VID_VALID_I(VID_VALID_I), .VID_X_I(VID_X_I), .VID_Y_I(VID_Y_I),
  .CROP_VALID_O(CROP_VALID_O), .CROP_X_O(CROP_X_O), .CROP_Y_O(CROP_Y_O),
  .LEDS_PER_OUTPUT_O(LEDS_PER_OUTPUT_O), .BIT_ENCODING_SELECT_O(BIT_ENCODING_SELECT_O),
  .PREEMPHASIS_ON_O(PREEMPHASIS_ON_O), .SLOT_TICK_O(SLOT_TICK_O), .SLOT_INDEX_O(SLOT_INDEX_O),
  .PIXEL_TICK_O(PIXEL_TICK_O), .LINE_DONE_O(LINE_DONE_O), .SERIAL_CLK_O(SERIAL_CLK_O));

// ---- test/led_display_config_regs_test.sv ----
// self-checking bench of the configuration register bank and strip timing
`timescale 1ns/1ns
`include "led_cfg_map.vh"
module led_display_config_regs_test;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic        clk = 1'b0, reset_n = 1'b0, reg_we = 1'b0, four_wire = 1'b0;
  logic        strip_run = 1'b0, vid_valid = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [10:0] vid_x = 11'h000, vid_y = 11'h000;
  logic [23:0] vid_data = 24'h000000;
  wire  [15:0] rdata;
  wire         crop_valid, preemph, slot_tick, pixel_tick, line_done, serial_clk;
  wire  [10:0] crop_x, crop_y;
  wire  [23:0] crop_data;
  wire  [9:0]  leds_len, seg_cnt, led_idx;
  wire  [4:0]  enc, slot_idx;
  int          error_cnt = 0, tests_run = 0, s0, s1, s3, sx;
  logic [35:0] rows [9];
  logic [15:0] rst [8];
  logic [4:0]  codes [3];
  logic [10:0] px [6], py [6];
  logic        kp [6], pre;
  led_display_config_regs led_display_config_regs_i (
    .CLK_I(clk), .RESET_N_I(reset_n), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WE_I(reg_we), .REG_RDATA_O(rdata), .FOUR_WIRE_I(four_wire), .STRIP_RUN_I(strip_run),
    .VID_VALID_I(vid_valid), .VID_X_I(vid_x), .VID_Y_I(vid_y), .VID_DATA_I(vid_data),
    .CROP_VALID_O(crop_valid), .CROP_X_O(crop_x), .CROP_Y_O(crop_y), .CROP_DATA_O(crop_data),
    .LEDS_PER_OUTPUT_O(leds_len), .SEGMENT_COUNT_O(seg_cnt), .BIT_ENCODING_SELECT_O(enc),
    .PREEMPHASIS_ON_O(preemph), .SLOT_TICK_O(slot_tick), .SLOT_INDEX_O(slot_idx),
    .PIXEL_TICK_O(pixel_tick), .LED_INDEX_O(led_idx), .LINE_DONE_O(line_done),
    .SERIAL_CLK_O(serial_clk));
  initial forever #4 clk = ~clk;
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    tests_run++;
    if (got > exp + tol || got + tol < exp) begin
      error_cnt++;
      $display("unexpected count at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr = a;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // counts are relative for 3-wire: pixels against slots, lines against pixels and slots between dividers are checked
  task automatic measure(input logic [15:0] dv, input logic fw, input int et, output int ns);
    int np, nl, nt;
    logic last;
    np = 0;
    nl = 0;
    nt = 0;
    ns = 0;
    wr(`OFS_SLOT_DIVIDER, dv);
    four_wire = fw;
    strip_run = 1'b1;
    repeat (100) @(negedge clk);
    last = serial_clk;
    repeat (7500) begin
      @(negedge clk);
      ns += (slot_tick === 1'b1);
      np += (pixel_tick === 1'b1);
      nl += (line_done === 1'b1);
      nt += (serial_clk !== last);
      last = serial_clk;
    end
    strip_run = 1'b0;
    if (fw) begin
      near(ns, 0, 0);
      near(nt, et, 2);
    end else begin
      near(np, ns / 24, 1);
      near(nl, np / 2, 1);
    end
    $display("test strip timing divider %0d four wire %0b done", dv, fw);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #760000;
    $display("run did not finish in time");
    error_cnt++;
    final_report;
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rows = '{36'h0_ffff_07ff, 36'h1_fabc_02bc, 36'h2_fc10_0010, 36'h3_0403_0003,
             36'h4_fc02_0002, 36'h5_0401_0001, 36'h6_0211_0000, 36'h7_0408_0008,
             36'ha_1234_0000};
    rst = '{16'h0000, 16'h0000, 16'h00ff, 16'h001f, 16'h0100, 16'h0000, 16'h0000, 16'h0000};
    codes = '{5'h00, 5'h01, 5'h10};
    px = '{11'h004, 11'h005, 11'h008, 11'h009, 11'h005, 11'h005};
    py = '{11'h002, 11'h002, 11'h003, 11'h003, 11'h004, 11'h001};
    kp = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][35:32], rows[i][31:16]);
      rd(rows[i][35:32], rows[i][15:0]);
    end
    chk(seg_cnt, 10'h008);
    chk(leds_len, 10'h002);
    // length 2 times 8 segments stays well inside the 512 budget
    $display("test register table done");
    for (int i = 0; i < 6; i++) begin
      four_wire = i[0];
      pre = (i < 3); // long-cable case first, pre-emphasis on
      wr(`OFS_ENC_PREEMPH, {6'h00, pre, 4'h0, codes[i % 3]});
      chk(enc, four_wire ? 5'h00 : codes[i % 3]);
      chk(preemph, pre);
    end
    four_wire = 1'b0;
    $display("test encoding and pre-emphasis done");
    wr(`OFS_CROP_LEFT, 16'h0005);
    wr(`OFS_CROP_TOP, 16'h0002);
    wr(`OFS_WIN_WIDTH, 16'h0003);
    wr(`OFS_WIN_HEIGHT, 16'h0001);
    for (int i = 0; i <= 6; i++) begin
      @(negedge clk);
      if (i > 0) begin
        chk(crop_valid, kp[i - 1]);
        if (kp[i - 1]) begin
          chk({crop_x, crop_y}, {px[i - 1] - 11'h005, py[i - 1] - 11'h002});
          chk(crop_data, {px[i - 1], 2'b00, py[i - 1]});
        end
      end
      vid_valid = (i < 6);
      vid_x = px[i % 6];
      vid_y = py[i % 6];
      vid_data = {px[i % 6], 2'b00, py[i % 6]};
    end
    vid_valid = 1'b0;
    $display("test crop window done");
    measure(16'h0000, 1'b0, 0, s0);
    measure(16'h0001, 1'b0, 0, s1);
    measure(16'h0003, 1'b0, 0, s3);
    near(int'(s0 > 40), 1, 0);
    near(s1 * 2, s0, 4);
    near(s3 * 4, s0, 8);
    measure(16'h0000, 1'b1, 960, sx);
    measure(16'h0002, 1'b1, 240, sx);
    measure(16'h0004, 1'b1, 60, sx);
    measure(16'h0009, 1'b1, 60, sx);
    four_wire = 1'b0;
    strip_run = 1'b1;
    repeat (50) @(negedge clk);
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    chk({leds_len, seg_cnt, enc, preemph, slot_tick}, {10'h100, 10'h000, 5'h00, 2'b00});
    strip_run = 1'b0;
    reset_n = 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0], rst[a]);
    end
    chk(led_idx, 10'h000);
    rd(`OFS_STATUS, 16'h0000);
    $display("test reset values done");
    final_report;
  end
endmodule // led_display_config_regs_test
